//--- sdsc_pkg.sv
package sdsc_pkg;

  // data and frame sizes
  localparam int DATA_W = 10;
  localparam int STEP_CNT_W_DEF = 12;
  localparam logic [3:0] HEAD_CNT = 4'h3;
  localparam logic [3:0] FRAME_CNT = 4'hd;
  localparam logic [3:0] READ_CNT = 4'ha;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // register select codes
  localparam logic [1:0] SEL_DIRECT_CODE = 2'h0;
  localparam logic [1:0] SEL_STEP_UP = 2'h1;
  localparam logic [1:0] SEL_STEP_DOWN = 2'h2;
  localparam logic [1:0] SEL_READBACK = 2'h3;

  // direction bit
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;

  // readback register fields
  localparam int READBACK_ENABLE_POS = 9;
  localparam int COMP_LEVEL_POS = 8;

  // code limits and reset values
  localparam logic [DATA_W-1:0] CODE_MAX = 10'h3ff;
  localparam logic [DATA_W-1:0] CODE_MIN = 10'h000;
  localparam logic [DATA_W-1:0] REG_RESET = 10'h000;
  localparam logic READBACK_ENABLE_RESET = 1'h0;

  typedef enum {SER_HEAD, SER_WRITE, SER_READ, SER_END} sdsc_ser_state_type;

  typedef struct packed {
    logic dir;
    logic [1:0] sel;
    logic [DATA_W-1:0] data;
  } sdsc_frame_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
    logic mode;
    logic up;
    logic down;
    logic dac_sel;
    logic ref_sel;
    logic ctrl_above;
  } sdsc_pins_type;

  typedef struct packed {
    logic atten_from_dac;
    logic dac_enable;
    logic dac_to_ctrl_pin;
    logic compare_active;
    logic ref_external;
  } sdsc_ctrl_type;

  // chip select idles high, every other pin low
  localparam sdsc_pins_type PINS_RESET = 9'h080;
  localparam sdsc_frame_type FRAME_RESET = 13'h0000;
  localparam sdsc_ctrl_type CTRL_RESET = 5'h00;

endpackage : sdsc_pkg

//--- sdsc_step_engine.sv
`timescale 1ns/1ps
module sdsc_step_engine
  import sdsc_pkg::*;
#(
  parameter int CNT_W = STEP_CNT_W_DEF
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // synchronised pins
  input wire logic step_mode,
  input wire logic up_level,
  input wire logic down_level,
  // step amounts
  input wire logic [DATA_W-1:0] up_amount,
  input wire logic [DATA_W-1:0] down_amount,
  // result
  output logic [DATA_W-1:0] step_code
);

  localparam int PROD_W = CNT_W + DATA_W;

  logic up_prev_reg, up_prev_next;
  logic down_prev_reg, down_prev_next;
  logic [CNT_W-1:0] up_cnt_reg, up_cnt_next;
  logic [CNT_W-1:0] down_cnt_reg, down_cnt_next;
  logic [DATA_W-1:0] code_reg, code_next;
  logic [PROD_W-1:0] up_total;
  logic [PROD_W-1:0] down_total;
  logic signed [PROD_W:0] diff;
  logic [DATA_W-1:0] clamped;
  logic up_rise, down_rise;

  always_comb
  begin
    up_total = up_cnt_reg * up_amount;
    down_total = down_cnt_reg * down_amount;
    diff = $signed({1'b0, up_total}) - $signed({1'b0, down_total});
    // no wraparound either way
    if (diff[PROD_W])
      clamped = CODE_MIN;
    else if (|diff[PROD_W-1:DATA_W])
      clamped = CODE_MAX;
    else
      clamped = diff[DATA_W-1:0];
    // the low phase arms the edge, so each step counts once
    up_rise = up_level & ~up_prev_reg;
    down_rise = down_level & ~down_prev_reg;
    up_prev_next = up_level;
    down_prev_next = down_level;
    up_cnt_next = up_cnt_reg;
    down_cnt_next = down_cnt_reg;
    // counts are frozen outside step mode so the code comes back
    if (step_mode)
    begin
      if (!up_level && !down_level)
      begin
        up_cnt_next = '0;
        down_cnt_next = '0;
      end
      else if (up_rise && down_level && clamped != CODE_MAX && !(&up_cnt_reg))
        up_cnt_next = up_cnt_reg + 1'b1;
      else if (down_rise && up_level && clamped != CODE_MIN && !(&down_cnt_reg))
        down_cnt_next = down_cnt_reg + 1'b1;
    end
    code_next = clamped;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      up_prev_reg <= 1'b0;
      down_prev_reg <= 1'b0;
      up_cnt_reg <= '0;
      down_cnt_reg <= '0;
      code_reg <= REG_RESET;
    end
    else
    begin
      up_prev_reg <= up_prev_next;
      down_prev_reg <= down_prev_next;
      up_cnt_reg <= up_cnt_next;
      down_cnt_reg <= down_cnt_next;
      code_reg <= code_next;
    end
  end

  assign step_code = code_reg;

endmodule : sdsc_step_engine

//--- sdsc_spi_dac_step_control.sv
`timescale 1ns/1ps
// Operation
// - frame is direction, two select, ten data
// - direction zero writes, one reads, sent first
// - select bits pick one of four registers
// - chip select rise stores complete write frame
// - early chip select rise drops write
// - read data shifts out after low select
// - output floats after ten bits or deselect
// - registers 0-2 hold ten-bit values
// - direct mode uses register 0, ignores steps
// - step code is ups times register 1 minus downs times register 2
// - both step inputs low clear accumulators in step mode
// - up rise with down high adds amount
// - down rise with up high subtracts amount
// - step code saturates between 0 and 1023
// - back to direct mode reapplies register 0
// - back to step mode restores step code
// - register 3 write sets readback enable
// - register 3 read: enable and comparator level
// - enable only: comparator goes low when control exceeds DAC
// - selector and enable both set: test drive
// - reference select picks internal or external
// - both zero: external voltage, DAC off
// - selector only: DAC drives attenuator
module sdsc_spi_dac_step_control
  import sdsc_pkg::*;
#(
  parameter int STEP_CNT_W = STEP_CNT_W_DEF
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // serial host
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT_O,
  output logic DOUT_OE_N,
  // mode and step pins
  input wire logic MODE,
  input wire logic STEP_UP,
  input wire logic STEP_DOWN_INPUT,
  // analog control pins
  input wire logic DAC_SELECT,
  input wire logic REF_SELECT,
  input wire logic CTRL_ABOVE_DAC,
  // DAC and switch controls
  output logic [DATA_W-1:0] DAC_CODE,
  output logic COMP_OUT,
  output logic COMPARATOR_READBACK_ENABLE,
  output logic ATTEN_FROM_DAC,
  output logic DAC_ENABLE,
  output logic DAC_TO_CTRL_PIN,
  output logic COMPARE_ACTIVE,
  output logic REF_EXTERNAL
);

  sdsc_pins_type pins_raw;
  sdsc_pins_type pins_meta_reg, pins_meta_next;
  sdsc_pins_type pins_sync_reg, pins_sync_next;
  sdsc_pins_type pins_prev_reg, pins_prev_next;
  logic sclk_rise, sclk_fall, cs_rise;

  sdsc_ser_state_type state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  sdsc_frame_type frame_reg, frame_next;
  logic [DATA_W-1:0] out_shift_reg, out_shift_next;
  logic [3:0] out_cnt_reg, out_cnt_next;
  logic dout_reg, dout_next;
  logic dout_oe_n_reg, dout_oe_n_next;

  logic [DATA_W-1:0] direct_code_reg, direct_code_next;
  logic [DATA_W-1:0] step_up_amount_reg, step_up_amount_next;
  logic [DATA_W-1:0] step_down_amount_reg, step_down_amount_next;
  logic comparator_readback_enable_reg, comparator_readback_enable_next;
  logic write_fire;

  logic [DATA_W-1:0] step_code;
  logic [DATA_W-1:0] dac_code_reg, dac_code_next;
  logic comp_out_reg, comp_out_next;
  sdsc_ctrl_type ctrl_reg, ctrl_next;

  function automatic logic [DATA_W-1:0] read_word(input logic [1:0] sel);
    logic [DATA_W-1:0] word;
    word = '0;
    unique case (sel)
      SEL_DIRECT_CODE: word = direct_code_reg;
      SEL_STEP_UP: word = step_up_amount_reg;
      SEL_STEP_DOWN: word = step_down_amount_reg;
      SEL_READBACK:
      begin
        word[READBACK_ENABLE_POS] = comparator_readback_enable_reg;
        word[COMP_LEVEL_POS] = comp_out_reg;
      end
    endcase
    return word;
  endfunction : read_word

  // every pin comes from outside the clock domain
  assign pins_raw = {SCLK, CS_N, DIN, MODE, STEP_UP, STEP_DOWN_INPUT, DAC_SELECT, REF_SELECT, CTRL_ABOVE_DAC};

  always_comb
  begin
    pins_meta_next = pins_raw;
    pins_sync_next = pins_meta_reg;
    pins_prev_next = pins_sync_reg;
    sclk_rise = pins_sync_reg.sclk & ~pins_prev_reg.sclk;
    sclk_fall = ~pins_sync_reg.sclk & pins_prev_reg.sclk;
    cs_rise = pins_sync_reg.cs_n & ~pins_prev_reg.cs_n;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pins_meta_reg <= PINS_RESET;
      pins_sync_reg <= PINS_RESET;
      pins_prev_reg <= PINS_RESET;
    end
    else
    begin
      pins_meta_reg <= pins_meta_next;
      pins_sync_reg <= pins_sync_next;
      pins_prev_reg <= pins_prev_next;
    end
  end

  // serial frame engine
  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    frame_next = frame_reg;
    out_shift_next = out_shift_reg;
    out_cnt_next = out_cnt_reg;
    dout_next = dout_reg;
    dout_oe_n_next = dout_oe_n_reg;
    // a write only counts with all thirteen bits in hand
    write_fire = cs_rise && state_reg == SER_WRITE && bit_cnt_reg == FRAME_CNT;
    if (pins_sync_reg.cs_n)
    begin
      state_next = SER_HEAD;
      bit_cnt_next = CNT_ZERO;
      out_cnt_next = CNT_ZERO;
      dout_oe_n_next = 1'b1;
    end
    else
    begin
      unique case (state_reg)
        SER_HEAD:
        begin
          if (sclk_rise)
          begin
            frame_next = {frame_reg[FRAME_CNT-2:0], pins_sync_reg.din};
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_next == HEAD_CNT)
            begin
              // header now sits in the low three bits of the shifter
              if (frame_next[2] == DIR_READ)
              begin
                state_next = SER_READ;
                out_shift_next = read_word(frame_next[1:0]);
              end
              else
                state_next = SER_WRITE;
            end
          end
        end
        SER_WRITE:
        begin
          // bits past the thirteenth are ignored
          if (sclk_rise && bit_cnt_reg != FRAME_CNT)
          begin
            frame_next = {frame_reg[FRAME_CNT-2:0], pins_sync_reg.din};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
        end
        SER_READ:
        begin
          if (sclk_fall)
          begin
            if (out_cnt_reg != READ_CNT)
            begin
              dout_next = out_shift_reg[DATA_W-1];
              dout_oe_n_next = 1'b0;
              out_shift_next = {out_shift_reg[DATA_W-2:0], 1'b0};
              out_cnt_next = out_cnt_reg + 4'h1;
            end
            else
            begin
              dout_oe_n_next = 1'b1;
              state_next = SER_END;
            end
          end
        end
        SER_END:
        begin
          dout_oe_n_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_reg <= SER_HEAD;
      bit_cnt_reg <= CNT_ZERO;
      frame_reg <= FRAME_RESET;
      out_shift_reg <= REG_RESET;
      out_cnt_reg <= CNT_ZERO;
      dout_reg <= 1'b0;
      dout_oe_n_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      frame_reg <= frame_next;
      out_shift_reg <= out_shift_next;
      out_cnt_reg <= out_cnt_next;
      dout_reg <= dout_next;
      dout_oe_n_reg <= dout_oe_n_next;
    end
  end

  // register file
  always_comb
  begin
    direct_code_next = direct_code_reg;
    step_up_amount_next = step_up_amount_reg;
    step_down_amount_next = step_down_amount_reg;
    comparator_readback_enable_next = comparator_readback_enable_reg;
    if (write_fire)
    begin
      unique case (frame_reg.sel)
        SEL_DIRECT_CODE: direct_code_next = frame_reg.data;
        SEL_STEP_UP: step_up_amount_next = frame_reg.data;
        SEL_STEP_DOWN: step_down_amount_next = frame_reg.data;
        // unused low bits are dropped rather than stored
        SEL_READBACK: comparator_readback_enable_next = frame_reg.data[READBACK_ENABLE_POS];
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      direct_code_reg <= REG_RESET;
      step_up_amount_reg <= REG_RESET;
      step_down_amount_reg <= REG_RESET;
      comparator_readback_enable_reg <= READBACK_ENABLE_RESET;
    end
    else
    begin
      direct_code_reg <= direct_code_next;
      step_up_amount_reg <= step_up_amount_next;
      step_down_amount_reg <= step_down_amount_next;
      comparator_readback_enable_reg <= comparator_readback_enable_next;
    end
  end

  sdsc_step_engine #(
    .CNT_W(STEP_CNT_W)
  ) step_engine (
    .clk(CLK),
    .rst(RST),
    .step_mode(pins_sync_reg.mode),
    .up_level(pins_sync_reg.up),
    .down_level(pins_sync_reg.down),
    .up_amount(step_up_amount_reg),
    .down_amount(step_down_amount_reg),
    .step_code(step_code)
  );

  // code source, comparator and switch controls
  always_comb
  begin
    if (pins_sync_reg.mode)
      dac_code_next = step_code;
    else
      dac_code_next = direct_code_reg;
    ctrl_next.atten_from_dac = pins_sync_reg.dac_sel;
    ctrl_next.dac_enable = pins_sync_reg.dac_sel | comparator_readback_enable_reg;
    // test drive of the control pin; not meant for normal use
    ctrl_next.dac_to_ctrl_pin = pins_sync_reg.dac_sel & comparator_readback_enable_reg;
    ctrl_next.compare_active = ~pins_sync_reg.dac_sel & comparator_readback_enable_reg;
    ctrl_next.ref_external = pins_sync_reg.ref_sel;
    // idles high so a trip reads as a falling level
    if (ctrl_next.compare_active)
      comp_out_next = ~pins_sync_reg.ctrl_above;
    else
      comp_out_next = 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      dac_code_reg <= REG_RESET;
      comp_out_reg <= 1'b1;
      ctrl_reg <= CTRL_RESET;
    end
    else
    begin
      dac_code_reg <= dac_code_next;
      comp_out_reg <= comp_out_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign DOUT_O = dout_reg;
  assign DOUT_OE_N = dout_oe_n_reg;
  assign DAC_CODE = dac_code_reg;
  assign COMP_OUT = comp_out_reg;
  assign COMPARATOR_READBACK_ENABLE = comparator_readback_enable_reg;
  assign ATTEN_FROM_DAC = ctrl_reg.atten_from_dac;
  assign DAC_ENABLE = ctrl_reg.dac_enable;
  assign DAC_TO_CTRL_PIN = ctrl_reg.dac_to_ctrl_pin;
  assign COMPARE_ACTIVE = ctrl_reg.compare_active;
  assign REF_EXTERNAL = ctrl_reg.ref_external;

endmodule : sdsc_spi_dac_step_control

//--- sdsc_spi_dac_step_control_sva.sv
`timescale 1ns/1ps
module sdsc_spi_dac_step_control_sva
  import sdsc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // pins
  input wire logic CS_N,
  input wire logic MODE,
  input wire logic STEP_UP,
  input wire logic STEP_DOWN_INPUT,
  input wire logic DAC_SELECT,
  input wire logic REF_SELECT,
  input wire logic CTRL_ABOVE_DAC,
  // outputs
  input wire logic DOUT_OE_N,
  input wire logic [DATA_W-1:0] DAC_CODE,
  input wire logic COMP_OUT,
  input wire logic COMPARATOR_READBACK_ENABLE,
  input wire logic ATTEN_FROM_DAC,
  input wire logic DAC_ENABLE,
  input wire logic DAC_TO_CTRL_PIN,
  input wire logic COMPARE_ACTIVE,
  input wire logic REF_EXTERNAL
);
  // pins pass a two-flop sync, so each check but a_rbe_write first waits out that latency
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic rbe;
  assign rbe = COMPARATOR_READBACK_ENABLE;

  property p_oe_release;
    CS_N [*4] |-> DOUT_OE_N;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("data out driven when deselected");

  property p_direct_hold;
    (!MODE && CS_N) [*6] |-> $stable(DAC_CODE);
  endproperty
  a_direct_hold: assert property (p_direct_hold) else $error("direct code moved");

  property p_step_clear;
    (MODE && !STEP_UP && !STEP_DOWN_INPUT) [*6] |-> DAC_CODE == CODE_MIN;
  endproperty
  a_step_clear: assert property (p_step_clear) else $error("step code not cleared");

  property p_dac_enable;
    ($stable(DAC_SELECT) && $stable(rbe)) [*5] |-> DAC_ENABLE == (DAC_SELECT | rbe);
  endproperty
  a_dac_enable: assert property (p_dac_enable) else $error("dac enable wrong");

  property p_test_drive;
    ($stable(DAC_SELECT) && $stable(rbe)) [*5] |-> DAC_TO_CTRL_PIN == (DAC_SELECT & rbe);
  endproperty
  a_test_drive: assert property (p_test_drive) else $error("test drive wrong");

  property p_atten;
    $stable(DAC_SELECT) [*5] |-> ATTEN_FROM_DAC == DAC_SELECT;
  endproperty
  a_atten: assert property (p_atten) else $error("attenuator source wrong");

  property p_ref;
    $stable(REF_SELECT) [*5] |-> REF_EXTERNAL == REF_SELECT;
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");

  property p_comp;
    ($stable(CTRL_ABOVE_DAC) && $stable(COMPARE_ACTIVE)) [*5] |-> COMP_OUT == !(COMPARE_ACTIVE && CTRL_ABOVE_DAC);
  endproperty
  a_comp: assert property (p_comp) else $error("comparator level wrong");

  property p_rbe_write;
    $changed(rbe) |-> $past(CS_N, 2) && !$past(CS_N, 5);
  endproperty
  a_rbe_write: assert property (p_rbe_write) else $error("readback enable moved outside a write");
endmodule : sdsc_spi_dac_step_control_sva

bind sdsc_spi_dac_step_control sdsc_spi_dac_step_control_sva u_sva (
  .CLK(CLK), .RST(RST), .CS_N(CS_N), .MODE(MODE), .STEP_UP(STEP_UP), .STEP_DOWN_INPUT(STEP_DOWN_INPUT),
  .DAC_SELECT(DAC_SELECT), .REF_SELECT(REF_SELECT), .CTRL_ABOVE_DAC(CTRL_ABOVE_DAC), .DOUT_OE_N(DOUT_OE_N),
  .DAC_CODE(DAC_CODE), .COMP_OUT(COMP_OUT), .COMPARATOR_READBACK_ENABLE(COMPARATOR_READBACK_ENABLE),
  .ATTEN_FROM_DAC(ATTEN_FROM_DAC), .DAC_ENABLE(DAC_ENABLE), .DAC_TO_CTRL_PIN(DAC_TO_CTRL_PIN),
  .COMPARE_ACTIVE(COMPARE_ACTIVE), .REF_EXTERNAL(REF_EXTERNAL)
);

//--- sdsc_host_model.sv
`timescale 1ns/1ps
module sdsc_host_model
  import sdsc_pkg::*;
(
  // clock
  input wire logic clk,
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  // mode and step pins
  output logic mode,
  output logic up,
  output logic down
);
  // output enable seen just before chip select rises
  logic end_oe_n;

  initial
  begin
    end_oe_n = 1'b1;
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    mode = 1'b0;
    up = 1'b0;
    down = 1'b0;
  end

  task automatic half;
    repeat (4) @(negedge clk);
  endtask : half

  // clock stands low between frames; fewer than 13 bits aborts the frame
  task automatic xfer(input sdsc_frame_type f, input int nbits, output logic [DATA_W-1:0] rd);
    logic [12:0] bits;
    bits = f;
    rd = 10'h000;
    @(negedge clk);
    cs_n = 1'b0;
    half();
    for (int i = 0; i < nbits; i++)
    begin
      din = bits[12-i];
      half();
      sclk = 1'b1;
      if (i > 2)
        rd[12-i] = dout_oe_n ? 1'bx : dout_o;
      half();
      sclk = 1'b0;
    end
    half();
    end_oe_n = dout_oe_n;
    cs_n = 1'b1;
    din = ~din;
    repeat (8) @(negedge clk);
  endtask : xfer

  // a step counts at the rising end while the other pin is high
  task automatic pins(input logic m, input logic u, input logic d);
    @(negedge clk);
    mode = m;
    up = u;
    down = d;
    repeat (8) @(negedge clk);
  endtask : pins
endmodule : sdsc_host_model

//--- tb_sdsc_spi_dac_step_control.sv
`timescale 1ns/1ps
module tb_sdsc_spi_dac_step_control;
  import sdsc_pkg::*;
  logic clk, rst, dac_sel, ref_sel, ctrl_above, sclk, cs_n, din, mode, up, down;
  logic dout_o, dout_oe_n, comp_out, rbe, atten, dac_en, dac_ctrl, cmp_act, ref_ext;
  logic [DATA_W-1:0] dac_code;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] regs [3];
  logic [1:0] s;
  int err_count;
  int total_checks;
  int m;
  int n;

  sdsc_spi_dac_step_control u_sdsc_spi_dac_step_control (
    .CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT_O(dout_o), .DOUT_OE_N(dout_oe_n),
    .MODE(mode), .STEP_UP(up), .STEP_DOWN_INPUT(down), .DAC_SELECT(dac_sel), .REF_SELECT(ref_sel),
    .CTRL_ABOVE_DAC(ctrl_above), .DAC_CODE(dac_code), .COMP_OUT(comp_out), .COMPARATOR_READBACK_ENABLE(rbe),
    .ATTEN_FROM_DAC(atten), .DAC_ENABLE(dac_en), .DAC_TO_CTRL_PIN(dac_ctrl), .COMPARE_ACTIVE(cmp_act),
    .REF_EXTERNAL(ref_ext)
  );

  sdsc_host_model u_sdsc_host_model (
    .clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
    .mode(mode), .up(up), .down(down)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [1:0] sel, input logic [DATA_W-1:0] val);
    u_sdsc_host_model.xfer({DIR_WRITE, sel, val}, 13, rd);
    if (sel != SEL_READBACK)
      regs[sel] = val;
  endtask : wr

  task automatic rdchk(input logic [1:0] sel, input logic [DATA_W-1:0] exp);
    u_sdsc_host_model.xfer({DIR_READ, sel, 10'h000}, 13, rd);
    check("read data", rd, exp);
    check("released after ten bits", u_sdsc_host_model.end_oe_n, 1'b1);
    check("dout released", dout_oe_n, 1'b1);
  endtask : rdchk

  function automatic logic [DATA_W-1:0] step_exp(input int mm, input int nn);
    int v;
    v = mm * int'(regs[1]) - nn * int'(regs[2]);
    return (v > 1023) ? CODE_MAX : (v < 0) ? CODE_MIN : v[DATA_W-1:0];
  endfunction : step_exp

  // no count once the code sits at its limit, so overshoot never accumulates
  task automatic step(input logic go_up);
    if (go_up && step_exp(m, n) != CODE_MAX)
      m++;
    if (!go_up && step_exp(m, n) != CODE_MIN)
      n++;
    u_sdsc_host_model.pins(1'b1, !go_up, go_up);
    u_sdsc_host_model.pins(1'b1, 1'b1, 1'b1);
    check("step code", dac_code, step_exp(m, n));
  endtask : step

  initial
  begin
    #2000000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    rst = 1'b1;
    dac_sel = 1'b0;
    ref_sel = 1'b0;
    ctrl_above = 1'b0;
    err_count = 0;
    total_checks = 0;
    m = 0;
    n = 0;
    foreach (regs[i]) regs[i] = REG_RESET;
    void'($urandom(21));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("reset code", dac_code, REG_RESET);
    for (int i = 0; i < 9; i++)
    begin
      s = (i < 3) ? i[1:0] : 2'($urandom_range(2));
      wr(s, (i == 1) ? CODE_MAX : 10'($urandom));
      rdchk(s, regs[s]);
      check("direct code", dac_code, regs[0]);
    end
    $display("test registers done");
    u_sdsc_host_model.xfer({DIR_WRITE, SEL_DIRECT_CODE, ~regs[0]}, 12, rd);
    rdchk(SEL_DIRECT_CODE, regs[0]);
    u_sdsc_host_model.xfer({DIR_READ, SEL_STEP_UP, 10'h000}, 8, rd);
    check("driving before deselect", u_sdsc_host_model.end_oe_n, 1'b0);
    check("early release", dout_oe_n, 1'b1);
    $display("test aborts done");
    for (int k = 0; k < 8; k++)
    begin
      @(negedge clk);
      dac_sel = k[0];
      ctrl_above = k[1];
      ref_sel = k[1] ^ k[2];
      wr(SEL_READBACK, {k[2], 9'h000});
      check("readback enable", rbe, k[2]);
      check("attenuator source", atten, k[0]);
      check("dac enable", dac_en, k[0] | k[2]);
      check("test drive", dac_ctrl, k[0] & k[2]);
      check("compare active", cmp_act, !k[0] && k[2]);
      check("comparator", comp_out, !(!k[0] && k[2] && k[1]));
      check("reference", ref_ext, k[1] ^ k[2]);
      rdchk(SEL_READBACK, {k[2], !(!k[0] && k[2] && k[1]), 8'h00});
    end
    wr(SEL_READBACK, 10'h000);
    $display("test readback done");
    wr(SEL_STEP_UP, 10'($urandom_range(399, 200)));
    wr(SEL_STEP_DOWN, 10'($urandom_range(399, 150)));
    u_sdsc_host_model.pins(1'b1, 1'b0, 1'b0);
    check("cleared code", dac_code, CODE_MIN);
    for (int i = 0; i < 24; i++)
      step(i < 6 || (i > 15 && $urandom_range(1) == 1));
    u_sdsc_host_model.pins(1'b0, 1'b1, 1'b1);
    check("direct again", dac_code, regs[0]);
    u_sdsc_host_model.pins(1'b0, 1'b0, 1'b0);
    check("no clear in direct", dac_code, regs[0]);
    u_sdsc_host_model.pins(1'b0, 1'b0, 1'b1);
    u_sdsc_host_model.pins(1'b0, 1'b1, 1'b1);
    check("steps ignored", dac_code, regs[0]);
    u_sdsc_host_model.pins(1'b1, 1'b1, 1'b1);
    check("step restored", dac_code, step_exp(m, n));
    $display("test steps done");
    wrap_up();
  end
endmodule : tb_sdsc_spi_dac_step_control
